// ### design/insn_decode_pkg.sv
/*
  Shared types and constants for the instruction decode and timing block.
  Assumes a single system clock; instruction words arrive from program memory.
*/
package insn_decode_pkg;
  localparam int WORD_W = 14;
  localparam int FILE_ADDR_W = 7;
  localparam int LIT8_W = 8;
  localparam int LIT11_W = 11;
  localparam int OSC_PER_CYCLE = 4;
  localparam logic [13:0] NOP_WORD = 14'h0000;
  localparam logic [13:0] SLEEP_WORD = 14'h0063;
  localparam logic [13:0] CLRWDT_WORD = 14'h0064;
  localparam logic [13:0] RETURN_WORD = 14'h0008;
  localparam logic [13:0] RETFIE_WORD = 14'h0009;
  localparam logic [1:0] GRP_BYTE = 2'h0;
  localparam logic [1:0] GRP_BIT = 2'h1;
  localparam logic [1:0] GRP_CTRL = 2'h2;
  localparam logic [1:0] GRP_LIT = 2'h3;
  localparam logic [3:0] OP_MOVWF = 4'h0;
  localparam logic [3:0] OP_CLR = 4'h1;
  localparam logic [3:0] OP_SUBWF = 4'h2;
  localparam logic [3:0] OP_DECF = 4'h3;
  localparam logic [3:0] OP_IORWF = 4'h4;
  localparam logic [3:0] OP_ANDWF = 4'h5;
  localparam logic [3:0] OP_XORWF = 4'h6;
  localparam logic [3:0] OP_ADDWF = 4'h7;
  localparam logic [3:0] OP_MOVF = 4'h8;
  localparam logic [3:0] OP_COMF = 4'h9;
  localparam logic [3:0] OP_INCF = 4'ha;
  localparam logic [3:0] OP_DECFSZ = 4'hb;
  localparam logic [3:0] OP_RRF = 4'hc;
  localparam logic [3:0] OP_ROTATE_LEFT_CARRY = 4'hd;
  localparam logic [3:0] OP_SWAPF = 4'he;
  localparam logic [3:0] OP_INCFSZ = 4'hf;
  localparam logic [1:0] BOP_CLEAR = 2'h0;
  localparam logic [1:0] BOP_SET = 2'h1;
  localparam logic [1:0] BOP_TEST_CLEAR = 2'h2;
  localparam logic [1:0] BOP_TEST_SET = 2'h3;

  typedef enum logic [1:0] {
    CLASS_BYTE = 2'h0,
    CLASS_BIT = 2'h1,
    CLASS_LITCTRL = 2'h2
  } insn_class_t;

  typedef struct packed {
    insn_class_t cls;
    logic [3:0] opcode;
    logic dest_file;
    logic [6:0] file_addr;
    logic [2:0] bit_num;
    logic [7:0] lit8;
    logic [10:0] lit11;
    logic writes_file;
    logic reads_file;
    logic is_branch;
    logic is_cond_skip;
    logic is_sleep;
    logic is_clear_file;
  } decoded_t;
endpackage

// ### design/insn_decode_timing.sv
/*
  Instruction decoder with read-modify-write sequencing and cycle timing.
  Assumes the datapath presents file read data within the read phase and
  i_skip_true is valid at the end of the write phase.
*/
`timescale 1ns/100ps
`default_nettype none
module insn_decode_timing
  import insn_decode_pkg::*;
#(
  parameter int OSC_DIV = OSC_PER_CYCLE,
  parameter logic [6:0] UPPER_IO_PORT_ADDR = 7'h06
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Program memory
  input wire logic [13:0] i_insn_word,
  // File register access
  input wire logic [7:0] i_file_rdata,
  input wire logic [7:0] i_port_pins,
  input wire logic i_skip_true,
  input wire logic [7:0] i_alu_result,
  // Decoded fields and timing
  output logic [13:0] o_insn_exec,
  output insn_decode_pkg::decoded_t o_decoded,
  output logic o_cycle_start,
  output logic [1:0] o_phase,
  output logic o_file_rd,
  output logic o_file_wr,
  output logic o_acc_wr,
  output logic [7:0] o_modify_operand,
  output logic [7:0] o_write_data,
  output logic o_port_change_clear,
  output logic o_fetch_next,
  output logic o_flush,
  output logic o_sleep_req
);
  import insn_decode_pkg::*;

  function automatic decoded_t decode(input logic [13:0] w);
    decoded_t dcd;
    dcd = '0;
    dcd.opcode = w[11:8];
    dcd.dest_file = w[7];
    dcd.file_addr = w[6:0];
    dcd.bit_num = w[9:7];
    dcd.lit8 = w[7:0];
    dcd.lit11 = w[10:0];
    unique case (w[13:12])
      GRP_BYTE: begin
        dcd.cls = CLASS_BYTE;
        dcd.reads_file = 1'b1;
        if (w[11:8] == OP_MOVWF) begin
          // Low control words share this opcode; bits 6:5 are don't-care for no_operation
          if (w[7]) begin
            dcd.writes_file = 1'b1;
          end else begin
            dcd.reads_file = 1'b0;
            dcd.is_sleep = (w == SLEEP_WORD);
            dcd.is_branch = (w == RETURN_WORD) || (w == RETFIE_WORD);
          end
        end else if (w[11:8] == OP_CLR) begin
          dcd.writes_file = w[7];
          dcd.is_clear_file = w[7];
          dcd.reads_file = w[7];
        end else begin
          // Covers rotate_left_carry 00 1101 d fffffff
          dcd.writes_file = w[7];
          dcd.is_cond_skip = (w[11:8] == OP_DECFSZ) || (w[11:8] == OP_INCFSZ);
        end
      end
      GRP_BIT: begin
        dcd.cls = CLASS_BIT;
        dcd.reads_file = 1'b1;
        dcd.writes_file = ~w[11];
        dcd.is_cond_skip = w[11];
      end
      GRP_CTRL: begin
        dcd.cls = CLASS_LITCTRL;
        dcd.is_branch = 1'b1;
      end
      GRP_LIT: begin
        dcd.cls = CLASS_LITCTRL;
        dcd.is_branch = (w[11:10] == 2'h1);
      end
    endcase
    return dcd;
  endfunction

  typedef enum logic [1:0] {
    ST_EXEC = 2'b01,
    ST_FLUSH = 2'b10
  } state_t;

  state_t state;
  state_t next_state;
  logic [1:0] phase;
  logic [13:0] insn_exec;
  logic [13:0] next_insn_exec;
  logic [7:0] rmw_value;

  // Phase divider: one instruction cycle per OSC_DIV clocks
  wire cycle_end = (phase == 2'(OSC_DIV - 1));
  wire decoded_t dec_now = decode(insn_exec);
  wire is_port = (dec_now.file_addr == UPPER_IO_PORT_ADDR);
  wire [7:0] read_value = is_port ? i_port_pins : i_file_rdata;
  wire in_exec = (state == ST_EXEC);
  wire take_two = in_exec && (dec_now.is_branch || (dec_now.is_cond_skip && i_skip_true));
  wire do_read = in_exec && dec_now.reads_file && (phase == 2'h1);
  wire do_write = in_exec && dec_now.reads_file && dec_now.writes_file && cycle_end;
  // Clear of accumulator has no file read but still writes it
  wire do_acc = in_exec && (dec_now.cls == CLASS_BYTE) && (dec_now.opcode != OP_MOVWF)
                && !dec_now.dest_file && !dec_now.is_cond_skip && cycle_end;
  wire is_clr_op = (dec_now.cls == CLASS_BYTE) && (dec_now.opcode == OP_CLR);
  wire [7:0] next_write = is_clr_op ? 8'h00 : i_alu_result;

  always_comb begin
    next_state = state;
    next_insn_exec = insn_exec;
    if (cycle_end) begin
      if (take_two) begin
        next_state = ST_FLUSH;
        next_insn_exec = NOP_WORD;
      end else begin
        next_state = ST_EXEC;
        next_insn_exec = i_insn_word;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase <= 2'h0;
      state <= ST_EXEC;
      insn_exec <= NOP_WORD;
      rmw_value <= 8'h00;
    end else begin
      phase <= cycle_end ? 2'h0 : phase + 2'h1;
      state <= next_state;
      insn_exec <= next_insn_exec;
      if (do_read) begin
        rmw_value <= read_value;
      end
    end
  end

  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_insn_exec <= NOP_WORD;
      o_decoded <= '0;
      o_cycle_start <= 1'b0;
      o_phase <= 2'h0;
      o_file_rd <= 1'b0;
      o_file_wr <= 1'b0;
      o_acc_wr <= 1'b0;
      o_modify_operand <= 8'h00;
      o_write_data <= 8'h00;
      o_port_change_clear <= 1'b0;
      o_fetch_next <= 1'b0;
      o_flush <= 1'b0;
      o_sleep_req <= 1'b0;
    end else begin
      o_insn_exec <= next_insn_exec;
      o_decoded <= decode(next_insn_exec);
      o_cycle_start <= cycle_end;
      o_phase <= cycle_end ? 2'h0 : phase + 2'h1;
      o_file_rd <= do_read;
      o_file_wr <= do_write;
      o_acc_wr <= do_acc;
      if (do_read) begin
        o_modify_operand <= read_value;
      end
      if (do_write || do_acc) begin
        o_write_data <= next_write;
      end
      o_port_change_clear <= do_write && is_port;
      o_fetch_next <= cycle_end;
      o_flush <= cycle_end && take_two;
      o_sleep_req <= in_exec && dec_now.is_sleep && cycle_end;
    end
  end
endmodule
`default_nettype wire

// ### verification/insn_decode_assertions.sv
/*
  Checker for the decode and timing block.
  Bound to the block; sees its ports only.
*/
`timescale 1ns/100ps
`default_nettype none
module insn_decode_checker
  import insn_decode_pkg::*;
#(
  parameter int OSC_DIV = OSC_PER_CYCLE
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Watched outputs
  input wire logic [13:0] o_insn_exec,
  input wire insn_decode_pkg::decoded_t o_decoded,
  input wire logic o_cycle_start,
  input wire logic [1:0] o_phase,
  input wire logic o_file_rd,
  input wire logic o_file_wr,
  input wire logic o_acc_wr,
  input wire logic [7:0] o_write_data,
  input wire logic o_port_change_clear,
  input wire logic o_flush,
  input wire logic o_sleep_req
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);
  int cnt;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt <= 0;
    end else begin
      cnt <= o_cycle_start ? 1 : cnt + 1;
    end
  end
  AST_PERIOD: assert property (o_cycle_start == (cnt == OSC_DIV))
    else $error("instruction cycle length wrong");
  AST_PHASE: assert property (o_cycle_start |-> o_phase == 2'h0)
    else $error("cycle start not at phase zero");
  AST_FIELDS: assert property (o_cycle_start |-> o_decoded.file_addr == o_insn_exec[6:0]
    && o_decoded.bit_num == o_insn_exec[9:7] && o_decoded.lit11 == o_insn_exec[10:0])
    else $error("fields not ready at cycle start");
  AST_HOLD: assert property (o_cycle_start |=> $stable(o_insn_exec) [*3])
    else $error("executing word changed mid cycle");
  AST_BIT_CLASS: assert property (o_cycle_start && o_insn_exec[13:12] == 2'h1
    |-> o_decoded.cls == CLASS_BIT) else $error("bit group not recognised");
  AST_ACC: assert property (o_acc_wr |-> !$past(o_decoded.dest_file) && !o_file_wr)
    else $error("accumulator write with file destination");
  AST_RMW: assert property (o_file_wr |-> $past(o_file_rd) || $past(o_file_rd, 2)
    || $past(o_file_rd, 3)) else $error("file write without prior read");
  AST_CLEAR: assert property (o_file_wr && $past(o_decoded.is_clear_file)
    |-> o_write_data == 8'h00) else $error("clear wrote nonzero data");
  AST_PORT: assert property (o_port_change_clear |-> o_file_wr)
    else $error("change clear without file write");
  AST_FLUSH: assert property (o_flush |-> ##[0:4] (o_cycle_start && o_insn_exec == NOP_WORD))
    else $error("flush not followed by idle cycle");
  AST_SLEEP: assert property (o_sleep_req |-> !o_flush)
    else $error("standby took two cycles");
endmodule
bind insn_decode_timing insn_decode_checker #(.OSC_DIV(OSC_DIV)) insn_decode_checker_i (.*);
`default_nettype wire

// ### verification/prog_mem_model.sv
/*
  Program memory model: presents the word at its counter.
  Assumes the counter steps on each fetch pulse of the core.
*/
`timescale 1ns/100ps
`default_nettype none
module prog_mem_model (
  // Core side
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  input wire logic i_fetch_next,
  output logic [13:0] o_word
);
  logic [13:0] mem [0:255];
  int pc;
  assign o_word = mem[pc[7:0]];
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pc <= 0;
    end else if (i_fetch_next) begin
      pc <= pc + 1;
    end
  end
endmodule
`default_nettype wire

// ### verification/test_mcu_instruction_decode_timing.sv
/*
  Bench: random legal program, cycle model checked at each start.
  Assumes the block, its package and the memory model are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module test_mcu_instruction_decode_timing;
  import insn_decode_pkg::*;
  logic i_clk_sys = 1'b0, i_rst_n = 1'b0, i_skip_true = 1'b0;
  logic [13:0] i_insn_word, o_insn_exec, w, pw = 14'h0000;
  logic [7:0] i_file_rdata = 8'h00, i_port_pins = 8'h00, i_alu_result = 8'h00;
  logic [7:0] o_modify_operand, o_write_data;
  logic [1:0] o_phase;
  logic o_cycle_start, o_file_rd, o_file_wr, o_acc_wr, o_port_change_clear;
  logic o_fetch_next, o_flush, o_sleep_req, fl, by, fsz, fw, aw;
  decoded_t o_decoded;
  int err_total = 0, checked = 0, seed = 30, idx = 0;
  always #5 i_clk_sys = ~i_clk_sys;
  insn_decode_timing insn_decode_timing_i (.*);
  prog_mem_model prog_mem_model_i (.i_clk_sys, .i_rst_n, .i_fetch_next(o_fetch_next),
    .o_word(i_insn_word));
  task automatic chk(input logic [19:0] seen, input logic [19:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict;
    if (err_total == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    for (int i = 0; i < 256; i++) begin
      w = 14'($random(seed));
      if (w[13:7] == 7'h00) w[7] = 1'b1;
      if (w[13:8] == 6'h3b) w[8] = 1'b0;
      if (i % 4 == 0) w[6:0] = 7'h06;
      prog_mem_model_i.mem[i] = w;
    end
    prog_mem_model_i.mem[0] = SLEEP_WORD;
    prog_mem_model_i.mem[3] = RETURN_WORD;
    prog_mem_model_i.mem[6] = RETFIE_WORD;
    prog_mem_model_i.mem[9] = 14'h0d86;
    prog_mem_model_i.mem[12] = 14'h0186;
    prog_mem_model_i.mem[15] = CLRWDT_WORD;
    repeat (8) @(posedge i_clk_sys);
    #1 i_rst_n = 1'b1;
    wait (idx >= 240);
    print_verdict;
  end
  initial begin
    #40000;
    err_total++;
    print_verdict;
  end
  always @(posedge i_clk_sys) begin
    #1;
    if (o_cycle_start === 1'b1) begin
      by = pw[13:12] == 2'h0 && pw[13:7] != 7'h00;
      fsz = by && (pw[11:8] == 4'hb || pw[11:8] == 4'hf);
      fl = pw[13:12] == 2'h2 || pw[13:10] == 4'hd || pw == RETURN_WORD
        || pw == RETFIE_WORD || (i_skip_true && (fsz || pw[13:11] == 3'h3));
      fw = (by && pw[7] && !fsz) || pw[13:11] == 3'h2;
      aw = by && !pw[7] && !fsz;
      chk(o_flush, fl);
      chk(o_sleep_req, pw == SLEEP_WORD);
      if (!fsz) chk({o_file_wr, o_acc_wr, o_port_change_clear}, {fw, aw, fw && pw[6:0] == 7'h06});
      if (fw || aw) chk(o_write_data, (by && pw[11:8] == 4'h1) ? 8'h00 : i_alu_result);
      if ((by && pw[11:7] != 5'h02) || pw[13:12] == 2'h1)
        chk(o_modify_operand, pw[6:0] == 7'h06 ? i_port_pins : i_file_rdata);
      w = fl ? NOP_WORD : prog_mem_model_i.mem[idx];
      idx++;
      chk(o_insn_exec, w);
      pw = w;
      if (w[13:7] != 7'h00)
        chk(o_decoded.cls, w[13] ? CLASS_LITCTRL : (w[12] ? CLASS_BIT : CLASS_BYTE));
      chk({o_decoded.dest_file, o_decoded.file_addr, o_decoded.bit_num}, {w[7:0], w[9:7]});
      chk({o_decoded.lit11, o_decoded.lit8}, {w[10:0], w[7:0]});
      {i_file_rdata, i_port_pins, i_alu_result} = 24'($random(seed));
      i_skip_true = 1'($random(seed));
    end
  end
endmodule
`default_nettype wire
